// ---- core/ssm_cfg.svh ----
// constants of the quality message adaptation: codes, bit positions, counts
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH

// message codes, most significant bit first
`define SSM_CODE_PRC      4'h2
`define SSM_CODE_SSUT     4'h4
`define SSM_CODE_SSUL     4'h8
`define SSM_CODE_SEC      4'hB
`define SSM_CODE_DNU      4'hF

// position of the message in the overhead byte (bit 5 = msb = [3])
`define SSM_MSG_MSB       3
`define SSM_MSG_LSB       0
`define SSM_S1_W          8

// frames of an unchanged code before it is accepted
`define SSM_ACCEPT_FRAMES 3

// width of a clock source identifier
`define SSM_CSID_W        8

// reset values
`define SSM_S1_RST        8'h0F
`define SSM_CSID_RST      8'h00

`endif

// ---- core/ssm_pkg.sv ----
// types and code conversion of the quality message adaptation
`default_nettype none
`include "ssm_cfg.svh"

package ssm_pkg;

  // quality levels carried between the adaptation and the distribution layer
  typedef enum logic [2:0] {
    QL_PRIMARY          = 3'h0,
    QL_TRANSIT          = 3'h1,
    QL_LOCAL            = 3'h2,
    QL_EQUIPMENT        = 3'h3,
    QL_NOT_USABLE       = 3'h4,
    LEVEL_NOT_SUPPORTED = 3'h5
  } ssm_ql_e;

  // management settings, quasi static
  typedef struct packed {
    logic quality_mode_select;
    logic quality_msg_tx_disable;
    logic quality_msg_rx_support;
  } ssm_mgmt_s;

  typedef logic [3:0] ssm_code_t;

  function automatic ssm_code_t ssm_encode(input ssm_ql_e ql);
    ssm_code_t c;
    c = `SSM_CODE_DNU;
    case (ql)
      QL_PRIMARY:   c = `SSM_CODE_PRC;
      QL_TRANSIT:   c = `SSM_CODE_SSUT;
      QL_LOCAL:     c = `SSM_CODE_SSUL;
      QL_EQUIPMENT: c = `SSM_CODE_SEC;
      default:      c = `SSM_CODE_DNU;
    endcase
    return c;
  endfunction

  function automatic ssm_ql_e ssm_decode(input ssm_code_t c);
    ssm_ql_e ql;
    ql = QL_NOT_USABLE;
    case (c)
      `SSM_CODE_PRC:  ql = QL_PRIMARY;
      `SSM_CODE_SSUT: ql = QL_TRANSIT;
      `SSM_CODE_SSUL: ql = QL_LOCAL;
      `SSM_CODE_SEC:  ql = QL_EQUIPMENT;
      default:        ql = QL_NOT_USABLE;
    endcase
    return ql;
  endfunction

endpackage

`default_nettype wire

// ---- core/ssm_persist.sv ----
// persistence filter: accepts a code seen in a run of consecutive frames
`default_nettype none
`include "ssm_cfg.svh"

module ssm_persist #(
  parameter int unsigned W      = 4,
  parameter int unsigned FRAMES = `SSM_ACCEPT_FRAMES
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // frame samples
  input  wire logic         enable,
  input  wire logic         sample,
  input  wire logic [W-1:0] code_in,
  // accepted code
  output logic      [W-1:0] accepted_q
);

  localparam int unsigned CNT_W = $clog2(FRAMES + 1);

  if (FRAMES < 2) begin : g_chk
    $error("ssm_persist: FRAMES must be at least 2");
  end

  logic [W-1:0]     cand_q;
  logic [W-1:0]     cand_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [W-1:0]     acc_d;

  // -------------------------------------------------------------------
  // run counting
  // -------------------------------------------------------------------
  always_comb begin
    cand_d = cand_q;
    cnt_d  = cnt_q;
    acc_d  = accepted_q;
    // run restarts on disable so a re-enable needs fresh frames
    if (!enable) begin
      cnt_d = '0;
    end else if (sample) begin
      if ((cnt_q != '0) && (code_in == cand_q)) begin
        if (cnt_q != CNT_W'(FRAMES)) begin
          cnt_d = CNT_W'(cnt_q + 1'b1);
        end
      end else begin
        cand_d = code_in;
        cnt_d  = CNT_W'(1);
      end
      if (cnt_d == CNT_W'(FRAMES)) begin
        acc_d = cand_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cand_q     <= '0;
      cnt_q      <= '0;
      accepted_q <= W'(`SSM_CODE_DNU);
    end else begin
      cand_q     <= cand_d;
      cnt_q      <= cnt_d;
      accepted_q <= acc_d;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_accept_run;
    @(posedge clk) disable iff (!rst_n)
    (enable && sample && (cnt_q == CNT_W'(FRAMES - 1)) && (code_in == cand_q))
      |=> (accepted_q == $past(code_in));
  endproperty
  a_accept_run: assert property (p_accept_run)
    else $error("code not accepted after full run");

  property p_no_early;
    @(posedge clk) disable iff (!rst_n)
    (accepted_q != $past(accepted_q))
      |-> ($past(cnt_q) == CNT_W'(FRAMES - 1)) && $past(sample && enable);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("accepted code changed before full run");

endmodule

`default_nettype wire

// ---- core/ssm_adapt.sv ----
// quality message adaptation: source insertion and sink extraction of S1 bits 5-8
// How it works
// - source maps primary, transit, local, equipment levels to 0010, 0100, 1000, 1011
// - quality mode disabled: source sends message 1111
// - returned remote identifier equals incoming identifier: source sends 1111
// - transmit disable set: source sends 1111
// - message sits in S1 bits 5 to 8, bit 5 most significant
// - sink samples bits each frame, accepts after three equal frames
// - sink converts accepted code to a level on its quality output
// - quality mode disabled: sink output forced to not supported
// - message support off: sink output forced to not supported
// - local identifier drives sink identifier and remote identifier outputs
// - recovered timing passes through to the timing output
`default_nettype none
`include "ssm_cfg.svh"

module ssm_adapt #(
  parameter int unsigned CSID_W = `SSM_CSID_W,
  parameter int unsigned FRAMES = `SSM_ACCEPT_FRAMES
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // management
  input  wire ssm_pkg::ssm_mgmt_s      mgmt,
  input  wire logic [CSID_W-1:0]       local_source_ident,
  // source side, from distribution layer and framer
  input  wire ssm_pkg::ssm_ql_e        tx_quality_level,
  input  wire logic [CSID_W-1:0]       tx_source_ident,
  input  wire logic                    tx_frame_start,
  input  wire logic [`SSM_S1_W-1:0]    tx_s1_in,
  // source side, to framer
  output logic      [`SSM_S1_W-1:0]    tx_s1_q,
  // sink side, from deframer
  input  wire logic                    rx_frame_start,
  input  wire logic [`SSM_S1_W-1:0]    rx_s1,
  input  wire logic                    trail_signal_fail,
  input  wire logic                    recovered_timing,
  // sink side, to distribution layer
  output var ssm_pkg::ssm_ql_e         quality_level_q,
  output logic                         server_signal_fail,
  output logic      [CSID_W-1:0]       source_ident_q,
  output logic      [CSID_W-1:0]       remote_source_ident_q,
  output logic                         frame_clock_q
);

  if (CSID_W < 1) begin : g_chk
    $error("ssm_adapt: CSID_W must be at least 1");
  end

  localparam int unsigned MW = `SSM_MSG_MSB - `SSM_MSG_LSB + 1;

  // -------------------------------------------------------------------
  // source: message selection
  // -------------------------------------------------------------------
  ssm_pkg::ssm_code_t      msg_q;
  ssm_pkg::ssm_code_t      msg_d;
  logic [`SSM_S1_W-1:0]    s1_d;
  logic                    loop_hit;

  assign loop_hit = (tx_source_ident == remote_source_ident_q);

  always_comb begin
    msg_d = msg_q;
    // message held over a frame, refreshed at its start
    if (tx_frame_start) begin
      if (!mgmt.quality_mode_select) begin
        msg_d = `SSM_CODE_DNU;
      end else if (loop_hit) begin
        msg_d = `SSM_CODE_DNU;
      end else if (mgmt.quality_msg_tx_disable) begin
        msg_d = `SSM_CODE_DNU;
      end else begin
        msg_d = ssm_pkg::ssm_encode(tx_quality_level);
      end
    end
  end

  always_comb begin
    s1_d = tx_s1_in;
    s1_d[`SSM_MSG_MSB:`SSM_MSG_LSB] = msg_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_q   <= `SSM_CODE_DNU;
      tx_s1_q <= `SSM_S1_RST;
    end else begin
      msg_q   <= msg_d;
      tx_s1_q <= s1_d;
    end
  end

  // -------------------------------------------------------------------
  // sink: extraction and level
  // -------------------------------------------------------------------
  logic                    rx_enable;
  logic [MW-1:0]           accepted;
  ssm_pkg::ssm_ql_e        ql_d;

  assign rx_enable = mgmt.quality_mode_select && mgmt.quality_msg_rx_support;

  ssm_persist #(
    .W      (MW),
    .FRAMES (FRAMES)
  ) u_persist (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (rx_enable),
    .sample     (rx_frame_start),
    .code_in    (rx_s1[`SSM_MSG_MSB:`SSM_MSG_LSB]),
    .accepted_q (accepted)
  );

  always_comb begin
    if (!mgmt.quality_mode_select) begin
      ql_d = ssm_pkg::LEVEL_NOT_SUPPORTED;
    end else if (!mgmt.quality_msg_rx_support) begin
      ql_d = ssm_pkg::LEVEL_NOT_SUPPORTED;
    end else begin
      ql_d = ssm_pkg::ssm_decode(accepted);
    end
  end

  assign server_signal_fail = trail_signal_fail;

  // -------------------------------------------------------------------
  // sink: identifiers and timing
  // -------------------------------------------------------------------
  logic [2:0]              tim_sync_q;
  logic [2:0]              tim_sync_d;
  logic                    tim_out_d;

  always_comb begin
    tim_sync_d = {tim_sync_q[1:0], recovered_timing};
    tim_out_d  = (tim_sync_q[1] == tim_sync_q[2]) ? tim_sync_q[2] : frame_clock_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quality_level_q       <= ssm_pkg::LEVEL_NOT_SUPPORTED;
      source_ident_q        <= CSID_W'(`SSM_CSID_RST);
      remote_source_ident_q <= CSID_W'(`SSM_CSID_RST);
      tim_sync_q            <= '0;
      frame_clock_q         <= 1'b0;
    end else begin
      quality_level_q       <= ql_d;
      source_ident_q        <= local_source_ident;
      remote_source_ident_q <= local_source_ident;
      tim_sync_q            <= tim_sync_d;
      frame_clock_q         <= tim_out_d;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_encode;
    @(posedge clk) disable iff (!rst_n)
    (tx_frame_start && mgmt.quality_mode_select && !loop_hit
      && !mgmt.quality_msg_tx_disable)
      |=> (msg_q == ssm_pkg::ssm_encode($past(tx_quality_level)))
      ##1 (tx_s1_q[`SSM_MSG_MSB:`SSM_MSG_LSB] == $past(msg_q));
  endproperty
  a_encode: assert property (p_encode)
    else $error("source level encoded wrongly");

  property p_mode_off_tx;
    @(posedge clk) disable iff (!rst_n)
    (tx_frame_start && !mgmt.quality_mode_select)
      |=> ##1 (tx_s1_q[`SSM_MSG_MSB:`SSM_MSG_LSB] == `SSM_CODE_DNU);
  endproperty
  a_mode_off_tx: assert property (p_mode_off_tx)
    else $error("disabled mode did not send all ones");

  property p_loop;
    @(posedge clk) disable iff (!rst_n)
    (tx_frame_start && (tx_source_ident == remote_source_ident_q))
      |=> (msg_q == `SSM_CODE_DNU);
  endproperty
  a_loop: assert property (p_loop)
    else $error("timing loop not blocked");

  property p_tx_dis;
    @(posedge clk) disable iff (!rst_n)
    (tx_frame_start && mgmt.quality_msg_tx_disable) |=> (msg_q == `SSM_CODE_DNU);
  endproperty
  a_tx_dis: assert property (p_tx_dis)
    else $error("transmit disable did not send all ones");

  property p_place;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (tx_s1_q[`SSM_S1_W-1:`SSM_MSG_MSB+1] == $past(tx_s1_in[`SSM_S1_W-1:4]))
      && (tx_s1_q[`SSM_MSG_MSB:`SSM_MSG_LSB] == $past(msg_q));
  endproperty
  a_place: assert property (p_place)
    else $error("message misplaced in overhead byte");

  property p_level;
    @(posedge clk) disable iff (!rst_n)
    (mgmt.quality_mode_select && mgmt.quality_msg_rx_support)
      |=> (quality_level_q == ssm_pkg::ssm_decode($past(accepted)));
  endproperty
  a_level: assert property (p_level)
    else $error("sink level does not follow accepted code");

  property p_unknown;
    @(posedge clk) disable iff (!rst_n)
    (rx_enable
      && !(accepted inside {`SSM_CODE_PRC, `SSM_CODE_SSUT, `SSM_CODE_SSUL, `SSM_CODE_SEC}))
      |=> (quality_level_q == ssm_pkg::QL_NOT_USABLE);
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unlisted code not mapped to not usable");

  property p_mode_off_rx;
    @(posedge clk) disable iff (!rst_n)
    !mgmt.quality_mode_select |=> (quality_level_q == ssm_pkg::LEVEL_NOT_SUPPORTED);
  endproperty
  a_mode_off_rx: assert property (p_mode_off_rx)
    else $error("disabled mode level not forced");

  property p_no_support;
    @(posedge clk) disable iff (!rst_n)
    !mgmt.quality_msg_rx_support |=> (quality_level_q == ssm_pkg::LEVEL_NOT_SUPPORTED);
  endproperty
  a_no_support: assert property (p_no_support)
    else $error("unsupported message level not forced");

  property p_ident;
    @(posedge clk) disable iff (!rst_n)
    $stable(local_source_ident) |=> (source_ident_q == $past(local_source_ident))
      && (remote_source_ident_q == $past(local_source_ident));
  endproperty
  a_ident: assert property (p_ident)
    else $error("identifier outputs do not follow local identifier");

  property p_timing;
    @(posedge clk) disable iff (!rst_n)
    (tim_sync_q[1] == tim_sync_q[2]) |=> (frame_clock_q == $past(tim_sync_q[2]));
  endproperty
  a_timing: assert property (p_timing)
    else $error("timing output does not follow recovered timing");

  property p_ssf;
    @(posedge clk) disable iff (!rst_n)
    server_signal_fail == trail_signal_fail;
  endproperty
  a_ssf: assert property (p_ssf)
    else $error("server signal fail differs from trail fail");

endmodule

`default_nettype wire

// ---- verif/ssm_framer_model.sv ----
// far-side framer model: frame pulses and overhead bytes
`default_nettype none
module ssm_framer_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic       tx_go,
  input  wire logic       rx_go,
  input  wire logic [3:0] rx_code,
  // toward the block
  output logic            tx_frame_start,
  output logic            rx_frame_start,
  output logic      [7:0] tx_s1_in,
  output logic      [7:0] rx_s1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pat_q = 4'h0;
  // pattern moves every cycle so stale bits never pass for valid ones
  always @(negedge clk) pat_q <= pat_q + 4'h1;
  assign tx_frame_start = tx_go;
  assign rx_frame_start = rx_go;
  assign tx_s1_in       = {pat_q, ~pat_q};
  assign rx_s1          = rx_go ? {pat_q, rx_code} : {~pat_q, pat_q};
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench of the quality message adaptation
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { int kind; int due; logic [7:0] exp; } ssm_note_s;
  logic               clk, rst_n, tx_go, rx_go, tsf, rtim, tx_fs, rx_fs, ssf, fclk, was_rst;
  logic [3:0]         rx_code;
  logic [7:0]         lid, txid, tx_s1_in, rx_s1, tx_s1_q, sid, rid, prev_in;
  ssm_pkg::ssm_mgmt_s mgmt;
  ssm_pkg::ssm_ql_e   txql, ql, prev;
  ssm_note_s          notes[$];
  int                 err_total = 0, comparisons = 0, cyc = 0;
  string              names[6] = '{"tx_msg", "quality", "src_id", "rmt_id", "ssf", "fclk"};
  logic [3:0]         enc[6] = '{4'h2, 4'h4, 4'h8, 4'hB, 4'hF, 4'hF};
  logic [3:0]         codes[6] = '{4'h2, 4'h4, 4'h8, 4'hB, 4'h0, 4'hF};
  ssm_pkg::ssm_ql_e   dec[6] = '{ssm_pkg::QL_PRIMARY, ssm_pkg::QL_TRANSIT, ssm_pkg::QL_LOCAL,
    ssm_pkg::QL_EQUIPMENT, ssm_pkg::QL_NOT_USABLE, ssm_pkg::QL_NOT_USABLE};

  ssm_adapt ssm_adapt_inst (.clk(clk), .rst_n(rst_n), .mgmt(mgmt), .local_source_ident(lid),
    .tx_quality_level(txql), .tx_source_ident(txid), .tx_frame_start(tx_fs),
    .tx_s1_in(tx_s1_in), .tx_s1_q(tx_s1_q), .rx_frame_start(rx_fs), .rx_s1(rx_s1),
    .trail_signal_fail(tsf), .recovered_timing(rtim), .quality_level_q(ql),
    .server_signal_fail(ssf), .source_ident_q(sid), .remote_source_ident_q(rid),
    .frame_clock_q(fclk));
  ssm_framer_model ssm_framer_model_inst (.clk(clk), .tx_go(tx_go), .rx_go(rx_go),
    .rx_code(rx_code), .tx_frame_start(tx_fs), .rx_frame_start(rx_fs),
    .tx_s1_in(tx_s1_in), .rx_s1(rx_s1));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(input int kind, input int dly, input logic [7:0] exp);
    notes.push_back('{kind, cyc + dly, exp});
  endtask
  function automatic logic [7:0] seen(input int k);
    case (k)
      0: return {4'h0, tx_s1_q[3:0]};
      1: return {5'h00, ql};
      2: return sid;
      3: return rid;
      4: return {7'h00, ssf};
      default: return {7'h00, fclk};
    endcase
  endfunction
  // watcher: settled values after each falling edge
  initial begin
    ssm_note_s n;
    prev_in = 8'h00;
    was_rst = 1'b0;
    forever begin
      @(negedge clk);
      #2;
      if (rst_n && was_rst) check("s1_upper", {prev_in[7:4], 4'h0}, {tx_s1_q[7:4], 4'h0});
      prev_in = tx_s1_in;
      was_rst = rst_n;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
        n = notes.pop_front();
        check(names[n.kind], n.exp, seen(n.kind));
      end
    end
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // caller lowers tx_go, so frames may run back to back
  task automatic tx_frame(input ssm_pkg::ssm_ql_e l, input logic [3:0] exp);
    txql = l;
    tx_go = 1'b1;
    note(0, 2, {4'h0, exp});
    @(negedge clk);
  endtask
  task automatic rx_frame(input logic [3:0] c);
    rx_code = c;
    rx_go = 1'b1;
    @(negedge clk);
    rx_go = 1'b0;
    tick($urandom_range(4, 1));
  endtask

  initial begin
    rst_n = 1'b0;
    {tx_go, rx_go, tsf, rtim} = 4'h0;
    rx_code = 4'h0;
    lid = 8'h5A;
    txid = 8'hA5;
    txql = ssm_pkg::QL_PRIMARY;
    mgmt = 3'b101; // mode on, tx enabled, rx supported
    void'($urandom(32'h387f69d6));
    tick(10);
    check("rst_s1", 8'h0F, tx_s1_q);
    check("rst_ql", {5'h00, ssm_pkg::LEVEL_NOT_SUPPORTED}, {5'h00, ql});
    rst_n = 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) tx_frame(ssm_pkg::ssm_ql_e'(i), enc[i]);
    for (int i = 0; i < 3; i++) begin
      mgmt.quality_mode_select = (i != 0);
      mgmt.quality_msg_tx_disable = (i == 1);
      txid = (i == 2) ? lid : ~lid;
      tx_frame(ssm_pkg::QL_PRIMARY, 4'hF);
    end
    txid = ~lid;
    tx_frame(ssm_pkg::QL_EQUIPMENT, 4'hB);
    tx_go = 1'b0;
    note(0, 4, {4'h0, 4'hB});
    tick(6);
    repeat (4) begin
      lid = 8'($urandom());
      txid = ~lid;
      note(2, 1, lid);
      note(3, 1, lid);
      tick(2);
    end
    repeat (6) begin
      tsf = 1'($urandom());
      rtim = ~rtim;
      note(4, 0, {7'h00, tsf});
      note(5, 4, {7'h00, rtim});
      tick(5);
    end
    prev = ssm_pkg::QL_NOT_USABLE;
    for (int i = 0; i < 6; i++) begin
      rx_frame(codes[i]);
      note(1, 2, {5'h00, prev});
      rx_frame(codes[i]);
      rx_frame(~codes[i]);
      repeat (2) rx_frame(codes[i]);
      note(1, 2, {5'h00, dec[i]});
      rx_frame(codes[i]);
      prev = dec[i];
    end
    for (int i = 0; i < 2; i++) begin
      mgmt.quality_mode_select = (i != 0);
      mgmt.quality_msg_rx_support = (i == 0);
      note(1, 1, {5'h00, ssm_pkg::LEVEL_NOT_SUPPORTED});
      tick(1);
      repeat (2) rx_frame(4'h4);
      note(1, 2, {5'h00, ssm_pkg::LEVEL_NOT_SUPPORTED});
      rx_frame(4'h4);
      mgmt = 3'b101;
      note(1, 2, {5'h00, prev});
      rx_frame(4'h4);
    end
    tick(4);
    rst_n = 1'b0;
    #2;
    check("rst2_s1", 8'h0F, tx_s1_q);
    check("rst2_ql", {5'h00, ssm_pkg::LEVEL_NOT_SUPPORTED}, {5'h00, ql});
    tick(2);
    rst_n = 1'b1;
    tick(4);
    wrap_up();
  end
endmodule
`default_nettype wire
